// *** pkg/ies_defines.svh ***
`ifndef IES_DEFINES_SVH
`define IES_DEFINES_SVH
// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define IES_OFS_CTRL       32'h0000_0000
`define IES_OFS_SHR        32'h0000_0004
`define IES_OFS_STATUS     32'h0000_0008
`define IES_OFS_EXCCNT     32'h0000_000c
`define IES_CTRL_EN_BIT    0
`define IES_CTRL_PNUM_LSB  8
`define IES_CTRL_ICIR_LSB  16
`define IES_CTRL_RST       32'h0000_0000
`define IES_SHR_RST        32'h0000_0000
// ----------------------------------------------------------------
// fixed memory locations and context block layout
// ----------------------------------------------------------------
`define IES_PAGE0_ICB_PTR  32'h0000_0014
`define IES_PAGE0_HANDLER  32'h0000_0018
`define IES_CXB_PREV_IDX   32'h0000_0000
`define IES_CXB_LEVEL      32'h0000_0004
`define IES_CXB_IDLE_SP    32'h0000_0008
`define IES_CXB_PREV_SP    32'h0000_000c
`define IES_CXB_INT_SP     32'h0000_0010
`define IES_PUSH_PC_OFS    32'h0000_0004
`define IES_PUSH_PSW_OFS   32'h0000_0008
`define IES_EXT_FRAME      32'h0000_0040
`define IES_IDLE_IDX_MARK  16'hffff
`define IES_STW_FLN_LSB    30
`define IES_FLN_EXTENDED   2'h1
`endif

// *** pkg/ies_pkg.sv ***
package ies_pkg;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        lock;
      logic        half;
      logic [7:0]  thr;
      logic [31:0] addr;
      logic [31:0] wdata;
   } ies_mem_req_t;

   typedef struct packed {
      logic        ack;
      logic        fault;
      logic [31:0] rdata;
   } ies_mem_rsp_t;

   typedef struct packed {
      logic        idle;
      logic        ring0;
      logic [31:0] next_pc;
      logic [31:0] stw;
      logic [31:0] sp;
   } ies_cpu_state_t;

   typedef struct packed {
      logic        valid;
      logic        thread_alloc;
      logic        stw_clear;
      logic [31:0] pc;
      logic [31:0] sp;
      logic [31:0] fp;
      logic [31:0] chan_report;
   } ies_cpu_load_t;

   typedef enum logic [3:0] {
      S_IDLE, S_CTX, S_PTR, S_HND, S_ISP, S_LVLR, S_LVLW, S_PCIR,
      S_SHR, S_PPC, S_PPSW, S_SSP, S_LDI, S_THR, S_FIN
   } ies_state_t;

   typedef enum logic [1:0] {
      P_IDLE, P_BASE, P_NEST
   } ies_path_t;
endpackage

// *** src/ies_sequencer.sv ***
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "ies_defines.svh"

//Function
// - accepting an interrupt clears complex interrupt-on flag
// - acceptance checks evaluated on every clock
// - context block pointer read from 0x14
// - fetch nesting halfword, zero means base level
// - increment nesting level back, indivisibly
// - pushed pc is next instruction
// - handler entered disabled, channel request cleared
// - non-resident context block raises machine exception
// - stack pointer equals frame pointer at handler
// - idle processor is base level, idle stack
// - idle: load context index, thread id first
// - idle: fetch pointer, handler, idle stack pointer
// - idle: level one, saved context index minus one
// - idle: push zero pc, extended frame status
// - idle: save stack pointer, load interrupt stack
// - finish: clear status, report channel, jump
// - active: fetch pointer, test level in process
// - active base: context switch then store level
// - active base, outside ring 0: allocate shared ring 0 stack
// - active base: push, save, load, new thread
// - active base: handler fetch after ring crossing
// - nested: store level, handler, push, save
// - channel report is 29 zeros, 3-bit code
module ies_sequencer #(
   parameter int unsigned NCHAN = 8
) (
   input  wire logic                   ref_clk_i,
   input  wire logic                   rst_b_i,
   input  wire logic                   psel_i,
   input  wire logic                   penable_i,
   input  wire logic                   pwrite_i,
   input  wire logic [31:0]            paddr_i,
   input  wire logic [31:0]            pwdata_i,
   output logic      [31:0]            prdata_o,
   output logic                        pready_o,
   output logic                        pslverr_o,
   input  wire logic [NCHAN-1:0]       irq_pend_i,
   input  wire logic                   eni_i,
   output logic                        ion_o,
   output logic      [NCHAN-1:0]       chan_clear_o,
   input  wire ies_pkg::ies_cpu_state_t cpu_i,
   output ies_pkg::ies_cpu_load_t      cpu_load_o,
   output logic      [4:0]             ctx_idx_o,
   output logic      [7:0]             ctx_thr_o,
   output ies_pkg::ies_mem_req_t       mem_req_o,
   input  wire ies_pkg::ies_mem_rsp_t  mem_rsp_i,
   output logic                        mach_exc_o,
   output logic                        busy_o
);
   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_meta_r;
   logic rst_sync_r;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [31:0]        ctrl_r;
   logic [31:0]        shr_r;
   logic [15:0]        exc_cnt_r;
   logic [2:0]         last_chan_r;
   ies_pkg::ies_state_t state_r;
   ies_pkg::ies_path_t  path_r;
   logic               ring0_r;
   logic [31:0]        pc_save_r;
   logic [31:0]        stw_save_r;
   logic [31:0]        sp_r;
   logic [31:0]        cxb_r;
   logic [31:0]        hnd_r;
   logic [15:0]        level_r;
   logic [2:0]         chan_r;
   logic               accept;
   logic [2:0]         pick;
   logic               is_mem;
   logic               op_write;
   logic               op_half;
   logic [31:0]        op_addr;
   logic [31:0]        op_wdata;
   logic               done;
   logic               fault;
   logic               apb_acc;

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   // one wait state: the answer is prepared while pready is low
   assign apb_acc = psel_i & penable_i & pready_o;

   always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else if (psel_i & penable_i & !pready_o) begin
         pready_o  <= 1'b1;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         if (paddr_i == `IES_OFS_CTRL) begin
            prdata_o <= ctrl_r;
         end else if (paddr_i == `IES_OFS_SHR) begin
            prdata_o <= shr_r;
         end else if (paddr_i == `IES_OFS_STATUS) begin
            prdata_o <= {24'h00_0000, 1'b0, last_chan_r, 2'h0, ion_o, busy_o};
         end else if (paddr_i == `IES_OFS_EXCCNT) begin
            prdata_o <= {16'h0000, exc_cnt_r};
         end else begin
            pslverr_o <= 1'b1;
         end
      end else begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         ctrl_r <= `IES_CTRL_RST;
         shr_r  <= `IES_SHR_RST;
      end else if (apb_acc & pwrite_i) begin
         if (paddr_i == `IES_OFS_CTRL) begin
            ctrl_r <= pwdata_i;
         end else if (paddr_i == `IES_OFS_SHR) begin
            shr_r <= pwdata_i;
         end
      end
   end

   // ----------------------------------------------------------------
   // acceptance
   // ----------------------------------------------------------------
   // lowest pending channel wins; looked at afresh every cycle
   always_comb begin
      pick = 3'h0;
      for (int i = NCHAN - 1; i >= 0; i--) begin
         if (irq_pend_i[i]) begin
            pick = 3'(i);
         end
      end
   end

   assign accept = ion_o & ctrl_r[`IES_CTRL_EN_BIT] & (|irq_pend_i)
                   & (state_r == ies_pkg::S_IDLE);

   always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         ion_o        <= 1'b0;
         chan_clear_o <= '0;
      end else begin
         chan_clear_o <= '0;
         if (accept) begin
            ion_o              <= 1'b0;
            chan_clear_o[pick] <= 1'b1;
         end else if (eni_i & (state_r == ies_pkg::S_IDLE)) begin
            // re-enable is ignored mid-sequence so the handler starts disabled
            ion_o <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // memory operation of each state
   // ----------------------------------------------------------------
   always_comb begin
      is_mem   = 1'b1;
      op_write = 1'b0;
      op_half  = 1'b0;
      op_addr  = 32'h0000_0000;
      op_wdata = 32'h0000_0000;
      case (state_r)
         ies_pkg::S_PTR: begin
            op_addr = `IES_PAGE0_ICB_PTR;
         end
         ies_pkg::S_HND: begin
            op_addr = `IES_PAGE0_HANDLER;
         end
         ies_pkg::S_ISP: begin
            op_addr = cxb_r + `IES_CXB_IDLE_SP;
         end
         ies_pkg::S_LVLR: begin
            op_half = 1'b1;
            op_addr = cxb_r + `IES_CXB_LEVEL;
         end
         ies_pkg::S_LVLW: begin
            op_write = 1'b1;
            op_half  = 1'b1;
            op_addr  = cxb_r + `IES_CXB_LEVEL;
            op_wdata = {16'h0000, level_r + 16'h0001};
         end
         ies_pkg::S_PCIR: begin
            op_write = 1'b1;
            op_half  = 1'b1;
            op_addr  = cxb_r + `IES_CXB_PREV_IDX;
            op_wdata = {16'h0000, `IES_IDLE_IDX_MARK};
         end
         ies_pkg::S_SHR: begin
            op_addr = shr_r;
         end
         ies_pkg::S_PPC: begin
            op_write = 1'b1;
            op_addr  = sp_r - `IES_PUSH_PC_OFS;
            op_wdata = pc_save_r;
         end
         ies_pkg::S_PPSW: begin
            op_write = 1'b1;
            op_addr  = sp_r - `IES_PUSH_PSW_OFS;
            op_wdata = stw_save_r;
         end
         ies_pkg::S_SSP: begin
            op_write = 1'b1;
            op_addr  = cxb_r + `IES_CXB_PREV_SP;
            op_wdata = sp_r - `IES_EXT_FRAME;
         end
         ies_pkg::S_LDI: begin
            op_addr = cxb_r + `IES_CXB_INT_SP;
         end
         default: begin
            is_mem = 1'b0;
         end
      endcase
   end

   assign done  = is_mem & mem_req_o.valid & mem_rsp_i.ack;
   assign fault = done & mem_rsp_i.fault;

   // ----------------------------------------------------------------
   // memory request
   // ----------------------------------------------------------------
   // the request is held steady until the ack, then dropped for a cycle
   always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         mem_req_o <= '0;
      end else begin
         mem_req_o.thr <= ctx_thr_o;
         if (mem_req_o.valid & mem_rsp_i.ack) begin
            mem_req_o.valid <= 1'b0;
            if (mem_rsp_i.fault | (state_r == ies_pkg::S_LVLW)) begin
               mem_req_o.lock <= 1'b0;
            end
         end else if (is_mem & !mem_req_o.valid) begin
            mem_req_o.valid <= 1'b1;
            mem_req_o.write <= op_write;
            mem_req_o.half  <= op_half;
            mem_req_o.addr  <= op_addr;
            mem_req_o.wdata <= op_wdata;
            if (state_r == ies_pkg::S_LVLR) begin
               mem_req_o.lock <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         state_r    <= ies_pkg::S_IDLE;
         path_r     <= ies_pkg::P_IDLE;
         ring0_r    <= 1'b0;
         pc_save_r  <= 32'h0000_0000;
         stw_save_r <= 32'h0000_0000;
         sp_r       <= 32'h0000_0000;
         cxb_r      <= 32'h0000_0000;
         hnd_r      <= 32'h0000_0000;
         level_r    <= 16'h0000;
         chan_r     <= 3'h0;
      end else if (fault) begin
         state_r <= ies_pkg::S_IDLE;
      end else begin
         case (state_r)
            ies_pkg::S_IDLE: begin
               if (accept) begin
                  chan_r     <= pick;
                  ring0_r    <= cpu_i.ring0;
                  sp_r       <= cpu_i.sp;
                  level_r    <= 16'h0000;
                  stw_save_r <= cpu_i.stw;
                  stw_save_r[`IES_STW_FLN_LSB+:2] <= `IES_FLN_EXTENDED;
                  if (cpu_i.idle) begin
                     path_r     <= ies_pkg::P_IDLE;
                     pc_save_r  <= 32'h0000_0000;
                     stw_save_r <= 32'h0000_0000;
                     stw_save_r[`IES_STW_FLN_LSB+:2] <= `IES_FLN_EXTENDED;
                     state_r    <= ies_pkg::S_CTX;
                  end else begin
                     path_r    <= ies_pkg::P_BASE;
                     pc_save_r <= cpu_i.next_pc;
                     state_r   <= ies_pkg::S_PTR;
                  end
               end
            end
            ies_pkg::S_CTX: begin
               state_r <= (path_r == ies_pkg::P_IDLE) ? ies_pkg::S_PTR
                                                      : ies_pkg::S_LVLW;
            end
            ies_pkg::S_PTR: begin
               if (done) begin
                  cxb_r   <= mem_rsp_i.rdata;
                  state_r <= (path_r == ies_pkg::P_IDLE) ? ies_pkg::S_HND
                                                         : ies_pkg::S_LVLR;
               end
            end
            ies_pkg::S_LVLR: begin
               if (done) begin
                  level_r <= mem_rsp_i.rdata[15:0];
                  if (mem_rsp_i.rdata[15:0] == 16'h0000) begin
                     state_r <= ies_pkg::S_CTX;
                  end else begin
                     path_r  <= ies_pkg::P_NEST;
                     state_r <= ies_pkg::S_LVLW;
                  end
               end
            end
            ies_pkg::S_LVLW: begin
               if (done) begin
                  if (path_r == ies_pkg::P_IDLE) begin
                     state_r <= ies_pkg::S_PCIR;
                  end else if ((path_r == ies_pkg::P_BASE) & !ring0_r) begin
                     state_r <= ies_pkg::S_SHR;
                  end else begin
                     state_r <= ies_pkg::S_HND;
                  end
               end
            end
            ies_pkg::S_SHR: begin
               if (done) begin
                  sp_r    <= mem_rsp_i.rdata;
                  state_r <= ies_pkg::S_HND;
               end
            end
            ies_pkg::S_HND: begin
               if (done) begin
                  hnd_r   <= mem_rsp_i.rdata;
                  state_r <= (path_r == ies_pkg::P_IDLE) ? ies_pkg::S_ISP
                                                         : ies_pkg::S_PPC;
               end
            end
            ies_pkg::S_ISP: begin
               if (done) begin
                  sp_r    <= mem_rsp_i.rdata;
                  state_r <= ies_pkg::S_LVLW;
               end
            end
            ies_pkg::S_PCIR: begin
               if (done) begin
                  state_r <= ies_pkg::S_PPC;
               end
            end
            ies_pkg::S_PPC: begin
               if (done) begin
                  state_r <= ies_pkg::S_PPSW;
               end
            end
            ies_pkg::S_PPSW: begin
               if (done) begin
                  state_r <= ies_pkg::S_SSP;
               end
            end
            ies_pkg::S_SSP: begin
               if (done) begin
                  // full extended frame is reserved even if only pc and status are written
                  sp_r    <= sp_r - `IES_EXT_FRAME;
                  state_r <= (path_r == ies_pkg::P_NEST) ? ies_pkg::S_FIN
                                                         : ies_pkg::S_LDI;
               end
            end
            ies_pkg::S_LDI: begin
               if (done) begin
                  sp_r    <= mem_rsp_i.rdata;
                  state_r <= (path_r == ies_pkg::P_BASE) ? ies_pkg::S_THR
                                                         : ies_pkg::S_FIN;
               end
            end
            ies_pkg::S_THR: begin
               state_r <= ies_pkg::S_FIN;
            end
            default: begin
               state_r <= ies_pkg::S_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // context, handover and status
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         ctx_idx_o <= 5'h00;
         ctx_thr_o <= 8'h00;
      end else if ((state_r == ies_pkg::S_CTX) | (state_r == ies_pkg::S_THR)) begin
         ctx_idx_o <= ctrl_r[`IES_CTRL_ICIR_LSB+:5];
         ctx_thr_o <= ctrl_r[`IES_CTRL_PNUM_LSB+:8];
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         cpu_load_o  <= '0;
         mach_exc_o  <= 1'b0;
         busy_o      <= 1'b0;
         exc_cnt_r   <= 16'h0000;
         last_chan_r <= 3'h0;
      end else begin
         cpu_load_o.valid        <= 1'b0;
         cpu_load_o.thread_alloc <= 1'b0;
         mach_exc_o              <= fault;
         busy_o                  <= (state_r != ies_pkg::S_IDLE) | accept;
         if (fault) begin
            exc_cnt_r <= exc_cnt_r + 16'h0001;
         end
         if (state_r == ies_pkg::S_FIN) begin
            cpu_load_o.valid        <= 1'b1;
            cpu_load_o.thread_alloc <= (path_r == ies_pkg::P_BASE);
            cpu_load_o.stw_clear    <= 1'b1;
            cpu_load_o.pc           <= hnd_r;
            cpu_load_o.sp           <= sp_r;
            cpu_load_o.fp           <= sp_r;
            cpu_load_o.chan_report  <= {29'h0000_0000, chan_r};
            last_chan_r             <= chan_r;
         end
      end
   end
endmodule

// *** test/ies_checker.sv ***
`timescale 1ns/10ps
module ies_checker #(
   parameter int unsigned NCHAN = 8
) (
   input wire logic                    ref_clk_i,
   input wire logic                    rst_b_i,
   input wire logic [NCHAN-1:0]        irq_pend_i,
   input wire logic                    ion_o,
   input wire logic [NCHAN-1:0]        chan_clear_o,
   input wire ies_pkg::ies_cpu_load_t  cpu_load_o,
   input wire ies_pkg::ies_mem_req_t   mem_req_o,
   input wire ies_pkg::ies_mem_rsp_t   mem_rsp_i,
   input wire logic                    mach_exc_o,
   input wire logic                    busy_o
);
   logic [2:0] chan_q;
   // ----------------------------------------------------------------
   // channel taken at accept, for the report check
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         chan_q <= 3'h0;
      end else begin
         for (int i = 0; i < NCHAN; i++) begin
            if (chan_clear_o[i]) begin
               chan_q <= 3'(i);
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   sequence s_accept;
      !busy_o ##1 busy_o;
   endsequence
   sequence s_load;
      cpu_load_o.valid;
   endsequence
   a_accept_off: assert property (s_accept |-> !ion_o && $onehot(chan_clear_o))
      else $error("accept without ion clear or one channel clear");
   a_clear_pulse: assert property (|chan_clear_o |=> chan_clear_o == '0)
      else $error("channel clear longer than one cycle");
   a_lowest_chan: assert property (|chan_clear_o |->
      chan_clear_o == ($past(irq_pend_i) & (~$past(irq_pend_i) + 1'b1)))
      else $error("cleared channel is not the lowest pending");
   a_single_seq: assert property (busy_o && $past(busy_o) |-> chan_clear_o == '0)
      else $error("new accept while busy");
   a_sp_fp: assert property (s_load |->
      cpu_load_o.sp == cpu_load_o.fp && cpu_load_o.stw_clear && !ion_o)
      else $error("handler entry state wrong");
   a_chan_report: assert property (s_load |-> cpu_load_o.chan_report == {29'h0, chan_q})
      else $error("channel report wrong");
   a_lock_busy: assert property (mem_req_o.lock |-> busy_o)
      else $error("lock outside a sequence");
   a_fault_exc: assert property (mem_req_o.valid && mem_rsp_i.ack && mem_rsp_i.fault
      |=> mach_exc_o && !cpu_load_o.valid)
      else $error("fault without machine exception");
   a_seq_bound: assert property ($rose(busy_o) |-> ##[1:600] !busy_o)
      else $error("sequence never ends");
endmodule

bind ies_sequencer ies_checker #(.NCHAN(NCHAN)) u_chk (
   .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .irq_pend_i(irq_pend_i), .ion_o(ion_o),
   .chan_clear_o(chan_clear_o), .cpu_load_o(cpu_load_o), .mem_req_o(mem_req_o),
   .mem_rsp_i(mem_rsp_i), .mach_exc_o(mach_exc_o), .busy_o(busy_o)
);

// *** test/ies_mem_model.sv ***
`timescale 1ns/10ps
module ies_mem_model (
   input wire logic                   clk_i,
   input wire logic                   rst_b_i,
   input wire ies_pkg::ies_mem_req_t  req_i,
   input wire logic [1:0]             lat_i,
   input wire logic                   fault_i,
   output ies_pkg::ies_mem_rsp_t      rsp_o
);
   logic [31:0] mem [256];
   logic [1:0]  cnt_r;
   logic        done_r;
   // ----------------------------------------------------------------
   // word memory, half accesses use the low 16 bits
   // ----------------------------------------------------------------
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rsp_o <= '0;
         cnt_r <= 2'h0;
         done_r <= 1'b0;
      end else begin
         rsp_o.ack <= 1'b0;
         rsp_o.fault <= 1'b0;
         // data is not held outside an answer
         rsp_o.rdata <= ~rsp_o.rdata;
         if (req_i.valid !== 1'b1) begin
            done_r <= 1'b0;
         end else if (!done_r && cnt_r != lat_i) begin
            cnt_r <= cnt_r + 2'h1;
         end else if (!done_r) begin
            done_r <= 1'b1;
            cnt_r <= 2'h0;
            rsp_o.ack <= 1'b1;
            rsp_o.fault <= fault_i;
            if (req_i.write && req_i.half) begin
               mem[req_i.addr[9:2]][15:0] <= req_i.wdata[15:0];
            end else if (req_i.write) begin
               mem[req_i.addr[9:2]] <= req_i.wdata;
            end else if (req_i.half) begin
               rsp_o.rdata <= {16'h0, mem[req_i.addr[9:2]][15:0]};
            end else begin
               rsp_o.rdata <= mem[req_i.addr[9:2]];
            end
         end
      end
   end
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
   logic                    clk = 1'b0;
   logic                    rst_b, psel, pen, pwr, eni, flt, pready, pslverr, complex_interrupt_on_flag, exc, busy, e;
   logic [31:0]             paddr, pwdata, prdata, r, nexc, cyc, err_total, checks;
   logic [7:0]              irq, clr, clr_q, thr;
   logic [4:0]              cix;
   logic [1:0]              lat;
   ies_pkg::ies_cpu_state_t cpu;
   ies_pkg::ies_cpu_load_t  ld_now, ld;
   ies_pkg::ies_mem_req_t   mreq;
   ies_pkg::ies_mem_rsp_t   mrsp;

   always #5 clk = ~clk;

   ies_sequencer u_dut (
      .ref_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .irq_pend_i(irq), .eni_i(eni), .ion_o(complex_interrupt_on_flag), .chan_clear_o(clr),
      .cpu_i(cpu), .cpu_load_o(ld_now), .ctx_idx_o(cix), .ctx_thr_o(thr),
      .mem_req_o(mreq), .mem_rsp_i(mrsp), .mach_exc_o(exc), .busy_o(busy));
   ies_mem_model u_mem (
      .clk_i(clk), .rst_b_i(rst_b), .req_i(mreq), .lat_i(lat), .fault_i(flt), .rsp_o(mrsp));

   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      checks = checks + 1;
      if (g !== x) begin
         err_total = err_total + 1;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask

   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk("read", x, r);
   endtask

   task automatic hold(input logic v);
      while (busy !== v) begin
         @(posedge clk);
      end
   endtask

   // pulses the re-enable, offers channels, waits out the whole sequence
   task automatic run(input logic [7:0] p);
      @(posedge clk);
      eni <= 1'b1;
      @(posedge clk);
      eni <= 1'b0;
      irq <= p;
      hold(1'b1);
      irq <= 8'h0;
      hold(1'b0);
   endtask

   task automatic ent(input logic [31:0] sp, input logic [7:0] c, input logic [31:0] ch);
      chk("pc", 32'h800, ld.pc);
      chk("sp", sp, ld.sp);
      chk("fp", sp, ld.fp);
      chk("chan", ch, ld.chan_report);
      chk("clear", {24'h0, c}, {24'h0, clr_q});
      chk("ion", 32'h0, {31'h0, complex_interrupt_on_flag});
   endtask

   task report_and_stop;
      if (err_total == 0 && checks != 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (ld_now.valid === 1'b1) ld <= ld_now;
      if (|clr) clr_q <= clr;
      if (exc === 1'b1) nexc <= nexc + 1;
      if (cyc > 20000) begin
         err_total = err_total + 1;
         report_and_stop();
      end
   end

   initial begin
      {rst_b, psel, pen, pwr, eni, flt, lat, irq} = '0;
      {paddr, pwdata, nexc, cyc, err_total, checks} = '0;
      cpu = '{1'b1, 1'b1, 32'h0, 32'h0, 32'h0};
      u_mem.mem[5] = 32'h40;
      u_mem.mem[6] = 32'h800;
      u_mem.mem[8] = 32'h200;
      u_mem.mem[17] = 32'h0;
      u_mem.mem[18] = 32'h100;
      u_mem.mem[20] = 32'h300;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      rdc(32'h0, 32'h0);
      rdc(32'h4, 32'h0);
      rdc(32'hc, 32'h0);
      apb(1'b0, 32'h10, 32'h0);
      chk("unmapped", 32'h1, {31'h0, e});
      apb(1'b1, 32'h0, 32'h0005_0301);
      apb(1'b1, 32'h4, 32'h20);
      rdc(32'h0, 32'h0005_0301);
      irq <= 8'h01;
      repeat (6) @(posedge clk);
      chk("busy", 32'h0, {31'h0, busy});
      irq <= 8'h0;
      run(8'h24);
      ent(32'h300, 8'h04, 32'h2);
      chk("cix", 32'h5, {27'h0, cix});
      chk("thr", 32'h3, {24'h0, thr});
      chk("mem thread", 32'h3, {24'h0, mreq.thr});
      chk("level", 32'h1, {16'h0, u_mem.mem[17][15:0]});
      chk("prev idx", 32'hffff, {16'h0, u_mem.mem[16][15:0]});
      chk("push pc", 32'h0, u_mem.mem[63]);
      chk("frame", 32'h1, {30'h0, u_mem.mem[62][31:30]});
      chk("prev sp", 32'hc0, u_mem.mem[19]);
      rdc(32'h8, 32'h20);
      lat <= 2'h3;
      cpu <= '{1'b0, 1'b1, 32'h1234, 32'hc000_0055, 32'h180};
      run(8'h80);
      ent(32'h140, 8'h80, 32'h7);
      chk("level", 32'h2, {16'h0, u_mem.mem[17][15:0]});
      chk("push pc", 32'h1234, u_mem.mem[95]);
      chk("push stw", 32'h4000_0055, u_mem.mem[94]);
      chk("prev sp", 32'h140, u_mem.mem[19]);
      chk("cix", 32'h5, {27'h0, cix});
      chk("thread", 32'h0, {31'h0, ld.thread_alloc});
      u_mem.mem[17] = 32'h0;
      lat <= 2'h1;
      cpu <= '{1'b0, 1'b0, 32'h1234, 32'hc000_0055, 32'h180};
      run(8'h10);
      ent(32'h300, 8'h10, 32'h4);
      chk("level", 32'h1, {16'h0, u_mem.mem[17][15:0]});
      chk("push pc", 32'h1234, u_mem.mem[127]);
      chk("push stw", 32'h4000_0055, u_mem.mem[126]);
      chk("prev sp", 32'h1c0, u_mem.mem[19]);
      chk("thread", 32'h1, {31'h0, ld.thread_alloc});
      flt <= 1'b1;
      run(8'h02);
      chk("exc", 32'h1, nexc);
      chk("no load", 32'h4, ld.chan_report);
      rdc(32'hc, 32'h1);
      report_and_stop();
   end
endmodule
